// File: byte_ram.sv
// byte-wide single-port ram with registered read data
`timescale 1ns/1ps
module byte_ram
    import lcd_pkg::*;
#(
    parameter int DEPTH = DD_DEPTH,
    parameter int AW = 7
) (
    // clock
    input wire logic clk,
    // port
    ram_port_if.mem port
);
    logic [7:0] mem [DEPTH];

    // ==========================================================
    // storage: no reset, contents are whatever software leaves
    always_ff @(posedge clk) begin
        if (port.we) begin
            mem[port.addr[AW-1:0]] <= port.wdata;
        end
    end

    // read data only moves on a read, so a held answer stays stable
    always_ff @(posedge clk) begin
        if (port.re) begin
            port.rdata <= mem[port.addr[AW-1:0]];
        end
    end
endmodule

// File: char_lcd_instruction_decoder.sv
// instruction decoder and execution control of a character lcd controller
`timescale 1ns/1ps
module char_lcd_instruction_decoder
    import lcd_pkg::*;
#(
    parameter int LONG_CYCLES = LONG_CYCLES_DEF,
    parameter int BLINK_CYCLES = BLINK_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // host transfer
    input wire logic bus_strobe,
    input wire logic register_select,
    input wire logic read_write_select,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out,
    output logic bus_data_valid,
    // state seen by the display side
    output logic operation_in_progress_flag,
    output logic [6:0] address_counter,
    output logic glyph_ram_selected,
    output logic address_step_direction,
    output logic display_shift_on_entry,
    output logic display_on,
    output logic cursor_on,
    output logic cursor_blink_on,
    output logic cursor_all_dots,
    output logic [5:0] display_shift_offset,
    output logic bus_width_select,
    output logic line_count_select,
    output logic font_height_select
);
    ram_port_if dd_bus ();
    ram_port_if cg_bus ();

    exec_state_t state;
    logic [CNT_W-1:0] exec_cnt;
    logic [BLINK_W-1:0] blink_cnt;
    logic blink_phase;
    logic nib_phase;
    logic [3:0] nib_hi;
    logic fill_active;
    logic [6:0] fill_idx;
    logic [7:0] resp_byte;
    logic rd_from_ram;
    logic rd_from_cg;
    logic rd_low_nib;
    logic [7:0] rd_byte;
    logic [7:0] full_byte;
    logic byte_done;
    logic rd_first;
    logic idle;
    logic instr_go;
    logic data_wr_go;
    logic data_rd_go;
    logic data_go;

    // ==========================================================
    // transfer assembly: 4-bit mode sends high nibble first
    assign idle = (state == ST_IDLE);
    assign full_byte = bus_width_select ? bus_data_in
                                        : {nib_hi, bus_data_in[7:4]};
    assign byte_done = bus_strobe & (bus_width_select | nib_phase);
    assign rd_first = bus_strobe & read_write_select
                      & (bus_width_select | ~nib_phase);
    // writes while busy are dropped; the host is expected to poll first
    assign instr_go = byte_done & ~register_select
                      & ~read_write_select & idle;
    assign data_wr_go = byte_done & register_select
                        & ~read_write_select & idle;
    assign data_rd_go = rd_first & register_select & idle;
    assign data_go = data_wr_go | data_rd_go;
    assign operation_in_progress_flag = ~idle;

    // nibble phase and held high nibble
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nib_phase <= 1'b0;
            nib_hi <= 4'h0;
        end else if (bus_width_select) begin
            nib_phase <= 1'b0;
        end else if (bus_strobe) begin
            nib_phase <= ~nib_phase;
            nib_hi <= bus_data_in[7:4];
        end
    end

    // ==========================================================
    // counter step with line wrap in display ram
    function automatic logic [6:0] step_ac(input logic [6:0] ac,
                                           input logic inc,
                                           input logic cg,
                                           input logic two);
        logic [6:0] r;
        r = inc ? ac + 7'h01 : ac - 7'h01;
        if (cg) begin
            r = {1'b0, r[5:0]};
        end else if (two) begin
            if (inc && ac == LINE1_END) r = LINE2_START;
            else if (inc && ac == LINE2_END) r = AC_HOME;
            else if (!inc && ac == AC_HOME) r = LINE2_END;
            else if (!inc && ac == LINE2_START) r = LINE1_END;
        end else begin
            if (inc && ac == ONE_LINE_END) r = AC_HOME;
            else if (!inc && ac == AC_HOME) r = ONE_LINE_END;
        end
        return r;
    endfunction

    function automatic logic [5:0] step_shift(input logic [5:0] o,
                                              input logic left);
        logic [5:0] r;
        r = o;
        if (left) r = (o == SHIFT_LAST) ? 6'h00 : o + 6'h01;
        else r = (o == 6'h00) ? SHIFT_LAST : o - 6'h01;
        return r;
    endfunction

    // address counter and ram selection, decoded by highest set bit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            address_counter <= AC_HOME;
            glyph_ram_selected <= RST_FLAG;
        end else if (instr_go) begin
            if (full_byte[7]) begin
                address_counter <= full_byte[6:0];
                glyph_ram_selected <= 1'b0;
            end else if (full_byte[6]) begin
                address_counter <= {1'b0, full_byte[5:0]};
                glyph_ram_selected <= 1'b1;
            end else if (full_byte[7:4] == 4'h1) begin
                if (!full_byte[SHIFT_SC_BIT]) begin
                    address_counter <= step_ac(address_counter,
                        full_byte[SHIFT_RL_BIT], glyph_ram_selected,
                        line_count_select);
                end
            end else if (full_byte[7:1] == 7'h01) begin
                address_counter <= AC_HOME;
            end else if (full_byte == 8'h01) begin
                address_counter <= AC_HOME;
                glyph_ram_selected <= 1'b0;
            end
        end else if (data_go) begin
            address_counter <= step_ac(address_counter,
                address_step_direction, glyph_ram_selected,
                line_count_select);
        end
    end

    // ==========================================================
    // mode latches from entry, display control and function set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            address_step_direction <= RST_INC;
            display_shift_on_entry <= RST_FLAG;
            display_on <= RST_FLAG;
            cursor_on <= RST_FLAG;
            cursor_blink_on <= RST_FLAG;
            bus_width_select <= RST_BUS_WIDTH;
            line_count_select <= RST_FLAG;
            font_height_select <= RST_FLAG;
        end else if (instr_go) begin
            if (full_byte[7:5] == 3'h1) begin
                bus_width_select <= full_byte[FS_DL_BIT];
                line_count_select <= full_byte[FS_N_BIT];
                font_height_select <= full_byte[FS_F_BIT];
            end else if (full_byte[7:3] == 5'h01) begin
                // one byte loads display, cursor and blink flags together
                display_on <= full_byte[DISP_ON_BIT];
                cursor_on <= full_byte[CUR_ON_BIT];
                cursor_blink_on <= full_byte[BLINK_BIT];
            end else if (full_byte[7:2] == 6'h01) begin
                address_step_direction <= full_byte[ENTRY_INC_BIT];
                display_shift_on_entry <= full_byte[ENTRY_SHIFT_BIT];
            end else if (full_byte == 8'h01) begin
                address_step_direction <= 1'b1;
            end
        end
    end

    // one shared offset moves both lines at once
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            display_shift_offset <= 6'h00;
        end else if (instr_go) begin
            if (full_byte[7:4] == 4'h1 && full_byte[SHIFT_SC_BIT]) begin
                display_shift_offset <= step_shift(display_shift_offset,
                    ~full_byte[SHIFT_RL_BIT]);
            end else if (full_byte[7:1] == 7'h01 || full_byte == 8'h01) begin
                display_shift_offset <= 6'h00;
            end
        end else if (data_wr_go && display_shift_on_entry
                     && !glyph_ram_selected) begin
            display_shift_offset <= step_shift(display_shift_offset,
                address_step_direction);
        end
    end

    // ==========================================================
    // execution timer; clear and home use the long count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            exec_cnt <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    exec_cnt <= '0;
                    if (instr_go && full_byte[7:1] == 7'h00
                        && full_byte[0]) begin
                        state <= ST_LONG;
                    end else if (instr_go && full_byte[7:1] == 7'h01) begin
                        state <= ST_LONG;
                    end else if (data_go
                                 || (instr_go && full_byte != 8'h00)) begin
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    exec_cnt <= exec_cnt + 1'b1;
                    if (exec_cnt == CNT_W'(EXEC_CYCLES - 1)) begin
                        state <= ST_IDLE;
                    end
                end
                ST_LONG: begin
                    exec_cnt <= exec_cnt + 1'b1;
                    if (exec_cnt == CNT_W'(LONG_CYCLES - 1)) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // space fill runs one address per cycle, well inside the long count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_active <= 1'b0;
            fill_idx <= 7'h00;
        end else if (instr_go && full_byte == 8'h01) begin
            fill_active <= 1'b1;
            fill_idx <= 7'h00;
        end else if (fill_active) begin
            fill_idx <= fill_idx + 7'h01;
            fill_active <= (fill_idx != FILL_LAST);
        end
    end

    // ==========================================================
    // ram ports
    assign dd_bus.we = fill_active | (data_wr_go & ~glyph_ram_selected);
    assign dd_bus.re = data_rd_go & ~glyph_ram_selected;
    assign dd_bus.addr = fill_active ? fill_idx : address_counter;
    assign dd_bus.wdata = fill_active ? SPACE_CODE : full_byte;
    assign cg_bus.we = data_wr_go & glyph_ram_selected;
    assign cg_bus.re = data_rd_go & glyph_ram_selected;
    assign cg_bus.addr = address_counter;
    assign cg_bus.wdata = full_byte;

    byte_ram #(.DEPTH(DD_DEPTH), .AW(7)) u_display_ram (
        .clk(clk),
        .port(dd_bus.mem)
    );
    byte_ram #(.DEPTH(CG_DEPTH), .AW(6)) u_glyph_ram (
        .clk(clk),
        .port(cg_bus.mem)
    );

    // ==========================================================
    // read answers, one cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            resp_byte <= 8'h00;
            rd_from_ram <= 1'b0;
            rd_from_cg <= 1'b0;
            rd_low_nib <= 1'b0;
            bus_data_valid <= 1'b0;
        end else begin
            bus_data_valid <= bus_strobe & read_write_select;
            if (bus_strobe && read_write_select) begin
                rd_low_nib <= ~bus_width_select & nib_phase;
            end
            if (rd_first && !register_select) begin
                // snapshot so both nibbles agree
                resp_byte <= {operation_in_progress_flag,
                              address_counter};
                rd_from_ram <= 1'b0;
            end else if (data_rd_go) begin
                rd_from_ram <= 1'b1;
                rd_from_cg <= glyph_ram_selected;
            end
        end
    end

    assign rd_byte = !rd_from_ram ? resp_byte
                   : rd_from_cg ? cg_bus.rdata : dd_bus.rdata;
    assign bus_data_out = bus_width_select ? rd_byte
                        : rd_low_nib ? {rd_byte[3:0], 4'h0}
                        : {rd_byte[7:4], 4'h0};

    // ==========================================================
    // blink timer; stopped and cleared while blink is off
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            blink_cnt <= '0;
            blink_phase <= 1'b0;
        end else if (!cursor_blink_on) begin
            blink_cnt <= '0;
            blink_phase <= 1'b0;
        end else if (blink_cnt == BLINK_W'(BLINK_CYCLES - 1)) begin
            blink_cnt <= '0;
            blink_phase <= ~blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end
    assign cursor_all_dots = cursor_blink_on & blink_phase;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    status_read_a: assert property (rd_first && !register_select
        && bus_width_select |=> bus_data_valid
        && bus_data_out == {$past(operation_in_progress_flag),
                            $past(address_counter)})
        else $error("status read wrong");
    clear_home_a: assert property (instr_go && full_byte == 8'h01
        |=> address_counter == AC_HOME && address_step_direction
        && display_shift_offset == 6'h00 && fill_active
        && state == ST_LONG)
        else $error("clear did not home");
    return_home_a: assert property (instr_go && full_byte[7:1] == 7'h01
        |=> address_counter == AC_HOME && display_shift_offset == 6'h00
        && !fill_active)
        else $error("return home wrong");
    entry_latch_a: assert property (instr_go && full_byte[7:2] == 6'h01
        |=> address_step_direction == $past(full_byte[1])
        && display_shift_on_entry == $past(full_byte[0]))
        else $error("entry mode not latched");
    func_set_a: assert property (instr_go && full_byte[7:5] == 3'h1
        |=> bus_width_select == $past(full_byte[4])
        && line_count_select == $past(full_byte[3]))
        else $error("function set not latched");
    glyph_addr_a: assert property (instr_go && full_byte[7:6] == 2'h1
        |=> glyph_ram_selected
        && address_counter == {1'b0, $past(full_byte[5:0])})
        else $error("glyph address set wrong");
    line_wrap_a: assert property (data_wr_go && line_count_select
        && address_step_direction && !glyph_ram_selected
        && address_counter == LINE1_END
        |=> address_counter == LINE2_START)
        else $error("no wrap to second line");
    exec_len_a: assert property ($rose(operation_in_progress_flag)
        && state == ST_EXEC |-> operation_in_progress_flag [*8])
        else $error("busy too short");
    exec_end_a: assert property ($fell(operation_in_progress_flag)
        && $past(state) == ST_EXEC
        |-> $past(exec_cnt) == CNT_W'(EXEC_CYCLES - 1))
        else $error("busy length wrong");
    long_end_a: assert property ($fell(operation_in_progress_flag)
        && $past(state) == ST_LONG
        |-> $past(exec_cnt) == CNT_W'(LONG_CYCLES - 1))
        else $error("long busy length wrong");
    disp_shift_a: assert property (instr_go && full_byte[7:3] == 5'h03
        |=> $stable(address_counter))
        else $error("display shift moved counter");

    clear_c: cover property (instr_go && full_byte == 8'h01
        ##1 fill_active [*8]);
    nibble_wr_c: cover property (!bus_width_select && data_wr_go);
    data_rd_c: cover property (data_rd_go ##1 bus_data_valid);
    blink_c: cover property (cursor_blink_on && $rose(cursor_all_dots));
endmodule

// File: host_model.sv
// host side model: single transfers and busy polling
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk,
    // host transfer
    output logic bus_strobe,
    output logic register_select,
    output logic read_write_select,
    output logic [7:0] bus_data_in,
    input wire logic [7:0] bus_data_out,
    input wire logic bus_data_valid
);
    // ==========================================================
    // bus driving
    initial begin
        bus_strobe = 1'b0;
        register_select = 1'b0;
        read_write_select = 1'b1;
        bus_data_in = 8'h00;
    end

    // one strobe; released data lines carry junk, never the last byte
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
        @(posedge clk);
        bus_strobe <= 1'b1;
        register_select <= rs;
        read_write_select <= rw;
        bus_data_in <= d;
        @(posedge clk);
        bus_strobe <= 1'b0;
        bus_data_in <= ~d;
        #1;
        q = bus_data_out;
        v = bus_data_valid;
    endtask

    // poll status until the busy flag reads low, bounded
    task automatic wait_ready(output logic ok);
        logic [7:0] q;
        logic v;
        ok = 1'b0;
        for (int i = 0; i < 2000 && !ok; i++) begin
            xfer(1'b0, 1'b1, 8'h00, q, v);
            ok = (q[7] === 1'b0);
        end
    endtask
endmodule

// File: lcd_pkg.sv
// constants, timing counts and types for the character lcd instruction decoder
package lcd_pkg;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int EXEC_TIME_NS = 18500;
    localparam int EXEC_CYCLES =
        (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LONG_TIME_NS = 760000;
    localparam int LONG_CYCLES_DEF =
        (LONG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLINK_TIME_NS = 185000000;
    localparam int BLINK_CYCLES_DEF = BLINK_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 17;
    localparam int BLINK_W = 25;

    // ==========================================================
    // memory geometry and codes
    localparam int DD_DEPTH = 128;
    localparam int CG_DEPTH = 64;
    localparam int ADDR_W = 7;
    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam logic [6:0] AC_HOME = 7'h00;
    localparam logic [6:0] LINE1_END = 7'h27;
    localparam logic [6:0] LINE2_START = 7'h40;
    localparam logic [6:0] LINE2_END = 7'h67;
    localparam logic [6:0] ONE_LINE_END = 7'h4f;
    localparam logic [6:0] FILL_LAST = 7'h7f;
    localparam logic [5:0] SHIFT_LAST = 6'h27;

    // ==========================================================
    // instruction field positions
    localparam int ENTRY_INC_BIT = 1;
    localparam int ENTRY_SHIFT_BIT = 0;
    localparam int DISP_ON_BIT = 2;
    localparam int CUR_ON_BIT = 1;
    localparam int BLINK_BIT = 0;
    localparam int SHIFT_SC_BIT = 3;
    localparam int SHIFT_RL_BIT = 2;
    localparam int FS_DL_BIT = 4;
    localparam int FS_N_BIT = 3;
    localparam int FS_F_BIT = 2;

    // ==========================================================
    // reset values
    localparam logic RST_BUS_WIDTH = 1'b1;
    localparam logic RST_INC = 1'b1;
    localparam logic RST_FLAG = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_LONG = 2'b10
    } exec_state_t;
endpackage

// File: ram_port_if.sv
// one synchronous ram port shared between the decoder and a ram
`timescale 1ns/1ps
interface ram_port_if;
    import lcd_pkg::*;
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output re, output addr, output wdata,
                  input rdata);
    modport mem (input we, input re, input addr, input wdata,
                 output rdata);
endinterface

// File: tb_char_lcd_instruction_decoder.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module tb_char_lcd_instruction_decoder;
    import lcd_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic stb, rs, rw, valid, busy, glyph, dir, sh_en, d_on, c_on, b_on;
    logic dots, bw, lines, font;
    logic [7:0] din, dout;
    logic [6:0] ac;
    logic [5:0] ofs;
    int failures = 0;
    int n_compared = 0;

    // ==========================================================
    // clock, design, host
    always #5 clk = ~clk;

    char_lcd_instruction_decoder #(.LONG_CYCLES(200), .BLINK_CYCLES(16)) uut (
        .clk(clk), .arst_n(arst_n), .bus_strobe(stb), .register_select(rs),
        .read_write_select(rw), .bus_data_in(din), .bus_data_out(dout),
        .bus_data_valid(valid), .operation_in_progress_flag(busy),
        .address_counter(ac), .glyph_ram_selected(glyph),
        .address_step_direction(dir), .display_shift_on_entry(sh_en),
        .display_on(d_on), .cursor_on(c_on), .cursor_blink_on(b_on),
        .cursor_all_dots(dots), .display_shift_offset(ofs),
        .bus_width_select(bw), .line_count_select(lines),
        .font_height_select(font));

    host_model host (.clk(clk), .bus_strobe(stb), .register_select(rs),
        .read_write_select(rw), .bus_data_in(din), .bus_data_out(dout),
        .bus_data_valid(valid));

    // ==========================================================
    // shared helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("FAIL %0t got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask

    task automatic cmd(input logic [7:0] d);
        logic [7:0] q;
        logic v, ok;
        host.xfer(1'b0, 1'b0, d, q, v);
        host.wait_ready(ok);
        check({7'h00, ok}, 8'h01);
    endtask

    // data read: valid pulse and byte, then wait out the busy time
    task automatic rd(input logic [7:0] exp);
        logic [7:0] q;
        logic v, ok;
        host.xfer(1'b1, 1'b1, 8'h00, q, v);
        check({7'h00, v}, 8'h01);
        check(q, exp);
        host.wait_ready(ok);
    endtask

    task automatic wr(input logic [7:0] d);
        logic [7:0] q;
        logic v, ok;
        host.xfer(1'b1, 1'b0, d, q, v);
        host.wait_ready(ok);
    endtask

    // one byte as two nibble transfers; answers reassembled high first
    task automatic nib_pair(input logic rs_i, input logic rw_i,
                            input logic [7:0] d, output logic [7:0] q);
        logic [7:0] q1;
        logic v;
        host.xfer(rs_i, rw_i, {d[7:4], 4'h0}, q1, v);
        host.xfer(rs_i, rw_i, {d[3:0], 4'h0}, q, v);
        q = {q1[7:4], q[7:4]};
    endtask

    // status polling cannot be used in 4-bit mode, so count the busy time
    task automatic nib_busy;
        repeat (EXEC_CYCLES - 1) @(posedge clk);
        #1;
        check({7'h00, busy}, 8'h01);
        @(posedge clk);
        #1;
        check({7'h00, busy}, 8'h00);
    endtask

    task automatic stop_test;
        if (failures == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_modes;
        int seen;
        seen = 0;
        check({dir, bw, glyph, d_on, 4'h0}, 8'hc0);
        cmd(8'h34);
        check({5'h00, bw, lines, font}, 8'h05);
        cmd(8'h38);
        check({6'h00, lines, font}, 8'h02);
        cmd(8'h0f);
        check({5'h00, d_on, c_on, b_on}, 8'h07);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            seen += (dots === 1'b1);
        end
        check({7'h00, seen > 0 && seen < 40}, 8'h01);
        cmd(8'h09);
        check({5'h00, d_on, c_on, dir}, 8'h01);
    endtask

    // line wrap on write, busy status, refused write, read back
    task automatic t_wrap;
        logic [7:0] q;
        logic v, ok;
        cmd(8'ha7);
        check({1'b0, ac}, 8'h27);
        host.xfer(1'b1, 1'b0, 8'h41, q, v);
        check({7'h00, busy}, 8'h01);
        host.xfer(1'b0, 1'b1, 8'h00, q, v);
        check(q, 8'hc0);
        host.xfer(1'b1, 1'b0, 8'h42, q, v);
        host.wait_ready(ok);
        check({1'b0, ac}, 8'h40);
        cmd(8'ha7);
        rd(8'h41);
        check({1'b0, ac}, 8'h40);
    endtask

    task automatic t_entry_shift;
        cmd(8'h04);
        wr(8'h55);
        check({1'b0, ac}, 8'h27);
        cmd(8'h07);
        wr(8'h56);
        check({ofs, dir, sh_en}, 8'h07);
        cmd(8'h14);
        check({1'b0, ac}, 8'h41);
        cmd(8'h10);
        check({1'b0, ac}, 8'h40);
        cmd(8'h18);
        check({1'b0, ac}, 8'h40);
        check({2'b00, ofs}, 8'h02);
        cmd(8'h1c);
        check({2'b00, ofs}, 8'h01);
        cmd(8'h03);
        check({ac, 1'b0}, 8'h00);
        check({2'b00, ofs}, 8'h00);
    endtask

    task automatic t_glyph_clear;
        cmd(8'h45);
        check({glyph, ac}, 8'h85);
        wr(8'haa);
        check({ofs, glyph, 1'b0}, 8'h02);
        check({1'b0, ac}, 8'h06);
        cmd(8'h45);
        rd(8'haa);
        cmd(8'h04);
        cmd(8'h01);
        check({glyph, ac}, 8'h00);
        check({7'h00, dir}, 8'h01);
        cmd(8'ha7);
        rd(8'h20);
        cmd(8'hff);
        rd(8'h20);
    endtask

    // 4-bit bus: address set, data write, status and data read
    task automatic t_nibble;
        logic [7:0] q;
        logic v;
        host.xfer(1'b0, 1'b0, 8'h28, q, v);
        nib_busy;
        check({7'h00, bw}, 8'h00);
        nib_pair(1'b0, 1'b0, 8'h85, q);
        nib_busy;
        check({1'b0, ac}, 8'h05);
        nib_pair(1'b1, 1'b0, 8'h3c, q);
        nib_busy;
        nib_pair(1'b0, 1'b1, 8'h00, q);
        check(q, 8'h06);
        nib_pair(1'b0, 1'b0, 8'h85, q);
        nib_busy;
        nib_pair(1'b1, 1'b1, 8'h00, q);
        check(q, 8'h3c);
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        t_modes;
        t_wrap;
        t_entry_shift;
        t_glyph_clear;
        t_nibble;
        stop_test;
    end

    initial begin
        #900000;
        failures++;
        stop_test;
    end
endmodule
